// ### verilog/hacd_top.sv
`timescale 1ns/10ps
`include "hacd_defs.svh"
module hacd_top (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  hacd_pkg::hacd_ext_req_t    ext_req,
   input  wire logic [3:0]            device_identity_pins,
   input  wire logic [19:0]           chan_rdata,
   input  wire logic                  chan_rack,
   output logic [7:0]                 ext_rdata_q,
   output logic                       ext_rvalid_q,
   output logic                       ext_busy_q,
   output hacd_pkg::hacd_chan_req_t   chan_req_q,
   output logic [7:0]                 sleep_q,
   output logic [7:0]                 pin_sync_q,
   output logic [7:0]                 soft_sync_q,
   output logic                       soft_sync_stb_q,
   output hacd_pkg::hacd_inport_cfg_t inport_a_cfg,
   output hacd_pkg::hacd_inport_cfg_t inport_b_cfg
);
   import hacd_pkg::*;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   hacd_state_t state_q;
   logic [7:0]  acr_q;
   logic [7:0]  car_q;
   logic [7:0]  dr_mid_q;
   logic [3:0]  dr_high_q;
   logic [19:0] rd_word_q;

   logic        take_wr;
   logic        take_rd;
   logic        accept;
   logic [3:0]  chan_mask;
   logic        inport_mode;
   logic        inport_hit;
   logic        low_wr;
   logic        low_rd;
   logic        ip_wr;
   logic        ip_rd_done;
   logic        chan_rd_start;
   logic        chan_rd_done;
   logic        access_done;
   logic [19:0] wr_word;
   logic [19:0] ip_rdata;
   logic [7:0]  reg_rdata;

   // ---------------------------------------------------------------
   // Request qualification
   // ---------------------------------------------------------------
   // Requests arriving while a channel read is outstanding are dropped;
   // ext_busy_q tells the host to hold off.
   assign take_wr = ext_req.wr && (state_q == HACD_IDLE);
   assign take_rd = ext_req.rd && !ext_req.wr && (state_q == HACD_IDLE);

   assign low_wr = take_wr && (ext_req.addr == `HACD_A_DR_LOW);
   assign low_rd = take_rd && (ext_req.addr == `HACD_A_DR_LOW);

   assign inport_mode = sleep_q[`HACD_SLEEP_INPORT];
   assign inport_hit  = inport_mode && (car_q[7:3] == `HACD_IP_SPAN);

   assign wr_word = {dr_high_q, dr_mid_q, ext_req.wdata};

   // ---------------------------------------------------------------
   // Selection decode
   // ---------------------------------------------------------------
   hacd_select u_select (
      .broadcast (acr_q[`HACD_ACR_BCAST]),
      .instr     (acr_q[`HACD_ACR_INSTR_HI:`HACD_ACR_INSTR_LO]),
      .identity  (device_identity_pins),
      .chan_sel  (acr_q[`HACD_ACR_CHAN_HI:`HACD_ACR_CHAN_LO]),
      .accept    (accept),
      .chan_mask (chan_mask)
   );

   // ---------------------------------------------------------------
   // Input-port control map
   // ---------------------------------------------------------------
   // Pointer above the map drops writes and reads back zero
   assign ip_wr      = low_wr && accept && inport_hit;
   assign ip_rd_done = low_rd && accept && inport_mode;

   hacd_input_port #(
      .REGS (8)
   ) u_input_port (
      .clk   (clk),
      .rst_b (rst_b),
      .wr_en (ip_wr),
      .index (car_q[2:0]),
      .wdata (wr_word),
      .rdata (ip_rdata),
      .cfg_a (inport_a_cfg),
      .cfg_b (inport_b_cfg)
   );

   // ---------------------------------------------------------------
   // Access completion
   // ---------------------------------------------------------------
   assign chan_rd_start = low_rd && accept && !inport_mode;
   // Acknowledge counts only while waiting; a stray pulse is ignored
   assign chan_rd_done  = (state_q == HACD_WAIT_CHAN) && chan_rack;
   // An ignored access, local or broadcast, leaves the pointer alone
   // Never meets a pointer write: strobes stall while busy
   assign access_done   = (low_wr && accept) || ip_rd_done || chan_rd_done;

   // ---------------------------------------------------------------
   // Read multiplexer for the non-triggering registers
   // ---------------------------------------------------------------
   // Low window answers zero here; its data takes the access path
   always_comb begin
      reg_rdata = `HACD_RST_BYTE;
      unique case (ext_req.addr)
         `HACD_A_ACR: begin
            reg_rdata = acr_q;
         end
         `HACD_A_CAR: begin
            reg_rdata = car_q;
         end
         `HACD_A_DR_MID: begin
            reg_rdata = rd_word_q[15:8];
         end
         `HACD_A_DR_HIGH: begin
            reg_rdata = {`HACD_RST_NIBBLE, rd_word_q[19:16]};
         end
         `HACD_A_DR_LOW: begin
            reg_rdata = `HACD_RST_BYTE;
         end
         `HACD_A_SLEEP, `HACD_A_PIN_SYNC, `HACD_A_SOFT_SYNC: begin
            // Write-only registers
            reg_rdata = `HACD_RST_BYTE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Access control register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acr_q <= `HACD_RST_BYTE;
      end else if (take_wr && ext_req.addr == `HACD_A_ACR) begin
         acr_q <= ext_req.wdata;
      end
   end

   // ---------------------------------------------------------------
   // Channel address pointer
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         car_q <= `HACD_RST_BYTE;
      end else if (take_wr && ext_req.addr == `HACD_A_CAR) begin
         car_q <= ext_req.wdata;
      end else if (access_done && acr_q[`HACD_ACR_AUTOINC]) begin
         car_q <= car_q + `HACD_CAR_STEP;
      end
   end

   // ---------------------------------------------------------------
   // Data window staging
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dr_mid_q  <= `HACD_RST_BYTE;
         dr_high_q <= `HACD_RST_NIBBLE;
      end else if (take_wr && ext_req.addr == `HACD_A_DR_MID) begin
         dr_mid_q <= ext_req.wdata;
      end else if (take_wr && ext_req.addr == `HACD_A_DR_HIGH) begin
         // Upper nibble of the byte is dropped
         dr_high_q <= ext_req.wdata[`HACD_DR_HIGH_MSB:0];
      end
   end

   // ---------------------------------------------------------------
   // Global control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_q <= `HACD_RST_BYTE;
      end else if (take_wr && ext_req.addr == `HACD_A_SLEEP) begin
         sleep_q <= ext_req.wdata & `HACD_SLEEP_USED;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_sync_q <= `HACD_RST_BYTE;
      end else if (take_wr && ext_req.addr == `HACD_A_PIN_SYNC) begin
         pin_sync_q <= ext_req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_sync_q     <= `HACD_RST_BYTE;
         soft_sync_stb_q <= 1'b0;
      end else begin
         soft_sync_stb_q <= take_wr && (ext_req.addr == `HACD_A_SOFT_SYNC);
         if (take_wr && ext_req.addr == `HACD_A_SOFT_SYNC) begin
            soft_sync_q <= ext_req.wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Internal channel request
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chan_req_q <= '0;
      end else begin
         chan_req_q.wr <= low_wr && accept && !inport_mode;
         chan_req_q.rd <= chan_rd_start;
         // Mask, address and data hold after the pulse
         // so a slow channel may still sample them
         if (low_wr || low_rd) begin
            chan_req_q.mask <= accept ? chan_mask : `HACD_MASK_NONE;
            chan_req_q.addr <= {acr_q[`HACD_ACR_CHAN_HI:`HACD_ACR_CHAN_LO], car_q};
            chan_req_q.data <= wr_word;
         end
      end
   end

   // ---------------------------------------------------------------
   // Read sequencing
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q    <= HACD_IDLE;
         ext_busy_q <= 1'b0;
      end else begin
         unique case (state_q)
            // One read in flight at most: no queue, so the
            // host port stalls for the whole channel wait
            HACD_IDLE: begin
               if (chan_rd_start) begin
                  state_q    <= HACD_WAIT_CHAN;
                  ext_busy_q <= 1'b1;
               end
            end
            HACD_WAIT_CHAN: begin
               // No timeout: a channel that never answers stalls the port
               if (chan_rack) begin
                  state_q    <= HACD_IDLE;
                  ext_busy_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // Readback under broadcast is delivered as-is and may be garbage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_word_q <= `HACD_RST_WORD;
      end else if (chan_rd_done) begin
         rd_word_q <= chan_rdata;
      end else if (ip_rd_done) begin
         rd_word_q <= inport_hit ? ip_rdata : `HACD_RST_WORD;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_rdata_q  <= `HACD_RST_BYTE;
         ext_rvalid_q <= 1'b0;
      end else begin
         ext_rvalid_q <= 1'b0;
         if (chan_rd_done) begin
            ext_rdata_q  <= chan_rdata[7:0];
            ext_rvalid_q <= 1'b1;
         end else if (ip_rd_done) begin
            ext_rdata_q  <= inport_hit ? ip_rdata[7:0] : `HACD_RST_BYTE;
            ext_rvalid_q <= 1'b1;
         end else if (take_rd && !chan_rd_start) begin
            ext_rdata_q  <= reg_rdata;
            ext_rvalid_q <= 1'b1;
         end
      end
   end

endmodule

// ### verilog/hacd_defs.svh
`ifndef HACD_DEFS_SVH
`define HACD_DEFS_SVH

// ---------------------------------------------------------------
// External register addresses
// ---------------------------------------------------------------
`define HACD_A_DR_LOW      3'h0
`define HACD_A_DR_MID      3'h1
`define HACD_A_DR_HIGH     3'h2
`define HACD_A_SLEEP       3'h3
`define HACD_A_PIN_SYNC    3'h4
`define HACD_A_SOFT_SYNC   3'h5
`define HACD_A_CAR         3'h6
`define HACD_A_ACR         3'h7

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HACD_ACR_AUTOINC   7
`define HACD_ACR_BCAST     6
`define HACD_ACR_INSTR_HI  5
`define HACD_ACR_INSTR_LO  2
`define HACD_ACR_CHAN_HI   1
`define HACD_ACR_CHAN_LO   0
`define HACD_SLEEP_INPORT  5
`define HACD_SLEEP_USED    8'h3F
`define HACD_DR_HIGH_MSB   3
`define HACD_GAIN_POL      4
`define HACD_GAIN_ILV      3
`define HACD_GAIN_HOLD_MSB 2
`define HACD_THR_MSB       9
`define HACD_DWELL_MSB     19

// ---------------------------------------------------------------
// Broadcast instruction codes and channel masks
// ---------------------------------------------------------------
`define HACD_BC_ALL        4'h0
`define HACD_BC_CH012      4'h1
`define HACD_BC_CH123      4'h2
`define HACD_BC_DEV_ALL    4'h4
`define HACD_BC_LSB0       4'h8
`define HACD_BC_LSB1       4'h9
`define HACD_BC_LOW00      4'hC
`define HACD_BC_LOW01      4'hD
`define HACD_BC_LOW10      4'hE
`define HACD_BC_LOW11      4'hF
`define HACD_MASK_ALL      4'hF
`define HACD_MASK_CH012    4'h7
`define HACD_MASK_CH123    4'hE
`define HACD_MASK_NONE     4'h0

// ---------------------------------------------------------------
// Input-port map
// ---------------------------------------------------------------
`define HACD_IP_SPAN       5'h00
`define HACD_IP_PER_INPUT  4
`define HACD_IP_LOW        2'h0
`define HACD_IP_HIGH       2'h1
`define HACD_IP_DWELL      2'h2
`define HACD_IP_GAIN       2'h3
`define HACD_THR_MASK      20'h003FF
`define HACD_DWELL_MASK    20'hFFFFF
`define HACD_GAIN_MASK     20'h0001F

// ---------------------------------------------------------------
// Reset values and steps
// ---------------------------------------------------------------
`define HACD_RST_BYTE      8'h00
`define HACD_RST_NIBBLE    4'h0
`define HACD_RST_WORD      20'h00000
`define HACD_CAR_STEP      8'h01

`endif

// ### verilog/hacd_pkg.sv
`include "hacd_defs.svh"
package hacd_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } hacd_ext_req_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  mask;
      logic [9:0]  addr;
      logic [19:0] data;
   } hacd_chan_req_t;

   typedef struct packed {
      logic [9:0]  low_thr;
      logic [9:0]  high_thr;
      logic [19:0] dwell;
      logic        polarity;
      logic        interleave;
      logic [2:0]  holdoff;
   } hacd_inport_cfg_t;

   typedef enum logic {HACD_IDLE, HACD_WAIT_CHAN} hacd_state_t;

   function automatic logic [3:0] hacd_onehot(input logic [1:0] sel);
      hacd_onehot = 4'h1 << sel;
   endfunction

   function automatic logic [19:0] hacd_ip_mask(input logic [1:0] kind);
      unique case (kind)
         `HACD_IP_LOW:   hacd_ip_mask = `HACD_THR_MASK;
         `HACD_IP_HIGH:  hacd_ip_mask = `HACD_THR_MASK;
         `HACD_IP_DWELL: hacd_ip_mask = `HACD_DWELL_MASK;
         `HACD_IP_GAIN:  hacd_ip_mask = `HACD_GAIN_MASK;
      endcase
   endfunction

endpackage

// ### verilog/hacd_select.sv
`timescale 1ns/10ps
`include "hacd_defs.svh"
module hacd_select (
   input  wire logic       broadcast,
   input  wire logic [3:0] instr,
   input  wire logic [3:0] identity,
   input  wire logic [1:0] chan_sel,
   output logic            accept,
   output logic [3:0]      chan_mask
);
   import hacd_pkg::*;

   always_comb begin
      accept    = 1'b0;
      chan_mask = hacd_onehot(chan_sel);
      if (!broadcast) begin
         accept = (instr == identity);
      end else begin
         unique case (instr)
            `HACD_BC_ALL: begin
               accept    = 1'b1;
               chan_mask = `HACD_MASK_ALL;
            end
            `HACD_BC_CH012: begin
               accept    = 1'b1;
               chan_mask = `HACD_MASK_CH012;
            end
            `HACD_BC_CH123: begin
               accept    = 1'b1;
               chan_mask = `HACD_MASK_CH123;
            end
            `HACD_BC_DEV_ALL: begin
               accept = 1'b1;
            end
            `HACD_BC_LSB0, `HACD_BC_LSB1: begin
               accept = (identity[0] == instr[0]);
            end
            `HACD_BC_LOW00, `HACD_BC_LOW01, `HACD_BC_LOW10, `HACD_BC_LOW11: begin
               accept = (identity[1:0] == instr[1:0]);
            end
            default: begin
               accept    = 1'b0;
               chan_mask = `HACD_MASK_NONE;
            end
         endcase
      end
   end

endmodule

// ### verilog/hacd_input_port.sv
`timescale 1ns/10ps
`include "hacd_defs.svh"
module hacd_input_port #(
   parameter int unsigned REGS = 8
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              wr_en,
   input  wire logic [2:0]        index,
   input  wire logic [19:0]       wdata,
   output logic [19:0]            rdata,
   output hacd_pkg::hacd_inport_cfg_t cfg_a,
   output hacd_pkg::hacd_inport_cfg_t cfg_b
);
   import hacd_pkg::*;

   logic [19:0]      reg_q [REGS];
   hacd_inport_cfg_t cfg   [2];

   // Each register keeps only its documented width
   for (genvar i = 0; i < REGS; i++) begin : g_reg
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            reg_q[i] <= `HACD_RST_WORD;
         end else if (wr_en && index == 3'(i)) begin
            reg_q[i] <= wdata & hacd_ip_mask(2'(i));
         end
      end
   end

   assign rdata = reg_q[index] & hacd_ip_mask(index[1:0]);

   for (genvar s = 0; s < 2; s++) begin : g_side
      localparam int unsigned B = s * `HACD_IP_PER_INPUT;
      assign cfg[s].low_thr    = reg_q[B + `HACD_IP_LOW][`HACD_THR_MSB:0];
      assign cfg[s].high_thr   = reg_q[B + `HACD_IP_HIGH][`HACD_THR_MSB:0];
      assign cfg[s].dwell      = reg_q[B + `HACD_IP_DWELL][`HACD_DWELL_MSB:0];
      assign cfg[s].polarity   = reg_q[B + `HACD_IP_GAIN][`HACD_GAIN_POL];
      assign cfg[s].interleave = reg_q[B + `HACD_IP_GAIN][`HACD_GAIN_ILV];
      assign cfg[s].holdoff    = reg_q[B + `HACD_IP_GAIN][`HACD_GAIN_HOLD_MSB:0];
   end

   assign cfg_a = cfg[0];
   assign cfg_b = cfg[1];

endmodule

// ### test/hacd_top_checker.sv
`timescale 1ns/10ps
module hacd_top_checker (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  hacd_pkg::hacd_ext_req_t  ext_req,
   input  wire logic                chan_rack,
   input  wire logic                ext_rvalid_q,
   input  wire logic                ext_busy_q,
   input  hacd_pkg::hacd_chan_req_t chan_req_q,
   input  wire logic [7:0]          sleep_q,
   input  wire logic [7:0]          pin_sync_q,
   input  wire logic [7:0]          soft_sync_q
);
   import hacd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic take_wr;
   logic take_rd;
   assign take_wr = ext_req.wr && !ext_busy_q;
   assign take_rd = ext_req.rd && !ext_req.wr && !ext_busy_q;

   a_reg_answer: assert property (take_rd && ext_req.addr != 3'h0 |=> ext_rvalid_q)
      else $error("register read not answered");
   a_read_busy: assert property (chan_req_q.rd |-> ext_busy_q && !ext_rvalid_q)
      else $error("channel read without busy");
   a_rack_done: assert property (ext_busy_q && chan_rack |=> ext_rvalid_q && !ext_busy_q)
      else $error("channel answer not returned");
   a_busy_mute: assert property (ext_busy_q && !chan_rack |=> !chan_req_q.wr && !chan_req_q.rd && !ext_rvalid_q)
      else $error("activity while busy");
   a_soft_value: assert property (take_wr && ext_req.addr == 3'h5 |=> soft_sync_q == $past(ext_req.wdata))
      else $error("soft sync value wrong");
   a_sleep_mask: assert property (take_wr && ext_req.addr == 3'h3 |=> sleep_q == {2'b00, $past(ext_req.wdata[5:0])})
      else $error("sleep value wrong");
   a_pin_value: assert property (take_wr && ext_req.addr == 3'h4 |=> pin_sync_q == $past(ext_req.wdata))
      else $error("pin sync value wrong");
   a_write_quiet: assert property (take_wr |=> !ext_rvalid_q)
      else $error("read answer after write");
   a_wr_target: assert property (chan_req_q.wr |-> chan_req_q.mask != 4'h0)
      else $error("channel write with no target");
   a_one_op: assert property (!(chan_req_q.wr && chan_req_q.rd))
      else $error("channel read and write together");
endmodule

bind hacd_top hacd_top_checker u_chk (
   .clk          (clk),
   .rst_b        (rst_b),
   .ext_req      (ext_req),
   .chan_rack    (chan_rack),
   .ext_rvalid_q (ext_rvalid_q),
   .ext_busy_q   (ext_busy_q),
   .chan_req_q   (chan_req_q),
   .sleep_q      (sleep_q),
   .pin_sync_q   (pin_sync_q),
   .soft_sync_q  (soft_sync_q)
);

// ### test/hacd_chan_model.sv
`timescale 1ns/10ps
module hacd_chan_model (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  hacd_pkg::hacd_chan_req_t chan_req,
   input  wire logic [3:0]          delay,
   output logic [19:0]              chan_rdata,
   output logic                     chan_rack
);
   import hacd_pkg::*;
   logic [19:0] mem [1024];
   logic [9:0]  rd_addr_q;
   int          cnt_q;

   // Idle data toggles so a stale word is never mistaken for an answer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= -1;
         chan_rack <= 1'b0;
         chan_rdata <= 20'h00000;
         rd_addr_q <= 10'h000;
      end else begin
         chan_rack <= 1'b0;
         chan_rdata <= ~chan_rdata;
         if (chan_req.wr)
            mem[chan_req.addr] <= chan_req.data;
         if (chan_req.rd) begin
            cnt_q <= int'(delay);
            rd_addr_q <= chan_req.addr;
         end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
         end else if (cnt_q == 0) begin
            cnt_q <= -1;
            chan_rack <= 1'b1;
            chan_rdata <= mem[rd_addr_q];
         end
      end
   end
endmodule

// ### test/test_host_access_channel_decode.sv
`timescale 1ns/10ps
module test_host_access_channel_decode;
   import hacd_pkg::*;
   logic             clk;
   logic             rst_b;
   hacd_ext_req_t    ext_req;
   logic [3:0]       id_pins;
   logic [3:0]       delay;
   logic [19:0]      chan_rdata;
   logic             chan_rack;
   logic [7:0]       ext_rdata_q;
   logic             ext_rvalid_q;
   logic             ext_busy_q;
   hacd_chan_req_t   chan_req_q;
   logic [7:0]       sleep_q;
   logic [7:0]       pin_sync_q;
   logic [7:0]       soft_sync_q;
   logic             soft_stb;
   hacd_inport_cfg_t cfg_a;
   hacd_inport_cfg_t cfg_b;
   logic [4:0]       exp;
   int               err_total;
   int               checks;

   hacd_top u_dut (.clk(clk), .rst_b(rst_b), .ext_req(ext_req), .device_identity_pins(id_pins),
      .chan_rdata(chan_rdata), .chan_rack(chan_rack), .ext_rdata_q(ext_rdata_q),
      .ext_rvalid_q(ext_rvalid_q), .ext_busy_q(ext_busy_q), .chan_req_q(chan_req_q),
      .sleep_q(sleep_q), .pin_sync_q(pin_sync_q), .soft_sync_q(soft_sync_q),
      .soft_sync_stb_q(soft_stb), .inport_a_cfg(cfg_a), .inport_b_cfg(cfg_b));
   hacd_chan_model u_chan (.clk(clk), .rst_b(rst_b), .chan_req(chan_req_q), .delay(delay),
      .chan_rdata(chan_rdata), .chan_rack(chan_rack));

   always #20 clk = ~clk;

   // ---------------------------------------------------------------
   // Host access tasks
   // ---------------------------------------------------------------
   task automatic test_done;
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp_v);
      checks++;
      if (seen !== exp_v) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp_v, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      ext_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      ext_req <= '0;
      #1;
   endtask
   // High and middle first: the low write launches the internal access
   task automatic word(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l);
      wr(3'h2, h);
      wr(3'h1, m);
      wr(3'h0, l);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
      int n;
      @(posedge clk);
      ext_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      ext_req <= '0;
      #1;
      n = 0;
      while (ext_rvalid_q !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("answer", 20'(ext_rvalid_q), 20'h1);
      chk(nm, 20'(ext_rdata_q), 20'(e));
   endtask
   // Returns {hit, mask} for broadcast code c, channel bits fixed at 1
   function automatic logic [4:0] sel(input logic [3:0] c, input logic [3:0] id);
      case (c)
         4'h0: sel = 5'h1F;
         4'h1: sel = 5'h17;
         4'h2: sel = 5'h1E;
         4'h4: sel = 5'h12;
         4'h8: sel = id[0] ? 5'h00 : 5'h12;
         4'h9: sel = id[0] ? 5'h12 : 5'h00;
         4'hC, 4'hD, 4'hE, 4'hF: sel = (id[1:0] == c[1:0]) ? 5'h12 : 5'h00;
         default: sel = 5'h00;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // Watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      test_done();
   end

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      ext_req = '0;
      id_pins = 4'h5;
      delay = 4'h0;
      err_total = 0;
      checks = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(3'h7, 8'h00, "acr_reset");
      rd(3'h6, 8'h00, "car_reset");
      wr(3'h7, 8'h96);
      wr(3'h6, 8'h3C);
      word(8'hA7, 8'h5B, 8'hC4);
      chk("chan_wr", 20'(chan_req_q.wr), 20'h1);
      chk("chan_mask", 20'(chan_req_q.mask), 20'h4);
      chk("chan_addr", 20'(chan_req_q.addr), 20'h23C);
      chk("chan_data", chan_req_q.data, 20'h75BC4);
      rd(3'h6, 8'h3D, "car_step");
      rd(3'h7, 8'h96, "acr_back");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         delay <= k[0] ? 4'h7 : 4'h0;
         wr(3'h6, 8'h3C);
         rd(3'h0, 8'hC4, "word_low");
         rd(3'h1, 8'h5B, "word_mid");
         rd(3'h2, 8'h07, "word_high");
         rd(3'h6, 8'h3D, "car_rd_step");
      end
      wr(3'h7, 8'h9A);
      wr(3'h0, 8'h00);
      chk("miss_wr", 20'(chan_req_q.wr), 20'h0);
      rd(3'h6, 8'h3D, "car_hold");
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         id_pins <= i[4] ? 4'hA : 4'h5;
         wr(3'h7, {2'b01, i[3:0], 2'b01});
         wr(3'h0, 8'h11);
         exp = sel(i[3:0], i[4] ? 4'hA : 4'h5);
         chk("bcast_hit", 20'(chan_req_q.wr), 20'(exp[4]));
         if (exp[4])
            chk("bcast_mask", 20'(chan_req_q.mask), 20'(exp[3:0]));
      end
      @(posedge clk);
      id_pins <= 4'h5;
      wr(3'h7, 8'h94);
      rd(3'h6, 8'h3D, "car_no_inc");
      wr(3'h3, 8'hFF);
      chk("sleep", 20'(sleep_q), 20'h3F);
      wr(3'h6, 8'h03);
      word(8'h00, 8'h00, 8'hFD);
      chk("in_map_wr", 20'(chan_req_q.wr), 20'h0);
      chk("gain_a", 20'({cfg_a.polarity, cfg_a.interleave, cfg_a.holdoff}), 20'h1D);
      word(8'h00, 8'hFF, 8'hFF);
      chk("thr_b", 20'(cfg_b.low_thr), 20'h3FF);
      chk("thr_a", 20'(cfg_a.low_thr), 20'h000);
      word(8'h00, 8'h02, 8'hAB);
      chk("thr_b_hi", 20'(cfg_b.high_thr), 20'h2AB);
      wr(3'h6, 8'h06);
      word(8'hF9, 8'h12, 8'h34);
      chk("dwell_b", cfg_b.dwell, 20'h91234);
      wr(3'h6, 8'h06);
      rd(3'h0, 8'h34, "dwell_low");
      rd(3'h1, 8'h12, "dwell_mid");
      rd(3'h2, 8'h09, "dwell_high");
      wr(3'h5, 8'h3A);
      chk("soft_sync", 20'(soft_sync_q), 20'h3A);
      chk("soft_stb", 20'(soft_stb), 20'h1);
      rd(3'h5, 8'h00, "soft_rd");
      chk("soft_stb_end", 20'(soft_stb), 20'h0);
      wr(3'h4, 8'h81);
      chk("pin_sync", 20'(pin_sync_q), 20'h81);
      test_done();
   end
endmodule
